// file: hw/dsp_pkg.sv
// Package with register map, field layout and timing constants for the display saver block.
package dsp_pkg;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [3:0] DSP_ADDR_SAVER_TIME   = 4'h2;
   localparam logic [3:0] DSP_ADDR_PROTECT_LVL  = 4'h3;
   localparam logic [3:0] DSP_ADDR_CTRL         = 4'h4;
   localparam logic [3:0] DSP_ADDR_STATUS       = 4'h5;
   localparam logic [3:0] DSP_ADDR_FUNC_EN      = 4'h6;

   // ----------------------------------------------------------------------
   // Control bits (register DSP_ADDR_CTRL)
   // ----------------------------------------------------------------------
   localparam int DSP_CTRL_TEST_PERMIT   = 0;
   localparam int DSP_CTRL_SAVER_OFF     = 2;
   localparam int DSP_CTRL_KEYWORD_REG   = 4;
   localparam int DSP_CTRL_MON_TEST_CFG  = 5;

   // ----------------------------------------------------------------------
   // Saver time encoding
   // ----------------------------------------------------------------------
   localparam logic [15:0] DSP_SAVER_DEFAULT_MIN = 16'h000a;
   localparam logic [15:0] DSP_SAVER_MAX_MIN     = 16'h00f0;
   localparam logic [15:0] DSP_ZERO16            = 16'h0000;

   // ----------------------------------------------------------------------
   // Protect levels
   // ----------------------------------------------------------------------
   localparam logic [15:0] DSP_PROTECT_LVL1 = 16'h0001;
   localparam logic [15:0] DSP_PROTECT_LVL2 = 16'h0002;

   // ----------------------------------------------------------------------
   // Function enable bit positions
   // ----------------------------------------------------------------------
   localparam int DSP_FN_TOP_TIME    = 0;
   localparam int DSP_FN_TOP_MON     = 1;
   localparam int DSP_FN_MON_TEST    = 2;
   localparam int DSP_FN_TEST        = 3;
   localparam int DSP_FN_ERR_CHECK   = 4;
   localparam int DSP_FN_PROTECT     = 5;
   localparam int DSP_FN_LANGUAGE    = 6;
   localparam int DSP_FN_CONTRAST    = 7;
   localparam int DSP_FN_TIME_SET    = 8;
   localparam int DSP_FN_KEY_CANCEL  = 9;
   localparam int DSP_FN_CASSETTE    = 10;
   localparam int DSP_FN_MON_TOP_TST = 11;
   localparam int DSP_FN_W           = 12;
   localparam logic [11:0] DSP_FN_ALL = 12'hfff;

   // ----------------------------------------------------------------------
   // Timing and scroll geometry
   // ----------------------------------------------------------------------
   localparam int DSP_CLK_HZ       = 10_000_000;
   localparam int DSP_MINUTE_S     = 60;
   localparam int DSP_MINUTE_CYC   = DSP_CLK_HZ * DSP_MINUTE_S;
   localparam int DSP_SCROLL_MS    = 500;
   localparam int DSP_SCROLL_CYC   = DSP_CLK_HZ / 1000 * DSP_SCROLL_MS;
   localparam logic [3:0] DSP_COL_LAST = 4'hb;
   localparam logic [1:0] DSP_ROW_LAST = 2'h3;

   // Saver state machine.
   typedef enum logic [1:0] {DSP_IDLE, DSP_SAVER, DSP_FORCED} dsp_state_t;

endpackage : dsp_pkg

// file: hw/dsp_scroll_if.sv
// Interface carrying the tick and scroll position between saver modules.
`timescale 1ns/10ps
`default_nettype none
interface dsp_scroll_if;
   logic       step;
   logic       run;
   logic [3:0] col;
   logic [1:0] row;
   modport src (output step, input run);
   modport pos (input step, input run, output col, output row);
endinterface : dsp_scroll_if
`default_nettype wire

// file: hw/dsp_tick_div.sv
// Divider that produces the minute enable and the scroll step enable.
`timescale 1ns/10ps
`default_nettype none
module dsp_tick_div
   import dsp_pkg::*;
#(
   parameter int MINUTE_CYC = DSP_MINUTE_CYC,
   parameter int SCROLL_CYC = DSP_SCROLL_CYC
) (
   // Clock and reset.
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   // Counter restart.
   input  wire logic i_restart,
   // Enables.
   output logic      o_minute,
   dsp_scroll_if.src scr
);
   logic [31:0] min_cnt_reg, min_cnt_next;
   logic [31:0] scr_cnt_reg, scr_cnt_next;
   logic        min_reg,     min_next;
   logic        step_reg,    step_next;

   // Next counts; the minute count restarts on a key or a setting change.
   always_comb begin
      min_next = 1'b0;
      step_next = 1'b0;
      if (i_restart || min_cnt_reg == 32'(MINUTE_CYC - 1)) begin
         min_cnt_next = 32'h0;
         min_next = !i_restart;
      end else begin
         min_cnt_next = min_cnt_reg + 32'h1;
      end
      if (!scr.run || scr_cnt_reg == 32'(SCROLL_CYC - 1)) begin
         scr_cnt_next = 32'h0;
         step_next = scr.run;
      end else begin
         scr_cnt_next = scr_cnt_reg + 32'h1;
      end
   end

   // Registers of the divider.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         min_cnt_reg <= 32'h0;
         scr_cnt_reg <= 32'h0;
         min_reg <= 1'b0;
         step_reg <= 1'b0;
      end else begin
         min_cnt_reg <= min_cnt_next;
         scr_cnt_reg <= scr_cnt_next;
         min_reg <= min_next;
         step_reg <= step_next;
      end
   end

   assign o_minute = min_reg;
   assign scr.step = step_reg;
endmodule : dsp_tick_div
`default_nettype wire

// file: hw/dsp_scroll_pos.sv
// Position walker for the moving saver picture.
`timescale 1ns/10ps
`default_nettype none
module dsp_scroll_pos
   import dsp_pkg::*;
(
   // Clock and reset.
   input  wire logic i_ref_clk,
   input  wire logic i_rst,
   // Position.
   dsp_scroll_if.pos scr
);
   logic [3:0] col_reg, col_next;
   logic [1:0] row_reg, row_next;

   // Column walks right to left; on wrap the row walks top to bottom.
   always_comb begin
      col_next = col_reg;
      row_next = row_reg;
      if (!scr.run) begin
         col_next = DSP_COL_LAST;
         row_next = 2'h0;
      end else if (scr.step) begin
         if (col_reg == 4'h0) begin
            col_next = DSP_COL_LAST;
            row_next = (row_reg == DSP_ROW_LAST) ? 2'h0 : row_reg + 2'h1;
         end else begin
            col_next = col_reg - 4'h1;
         end
      end
   end

   // Position registers.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         col_reg <= DSP_COL_LAST;
         row_reg <= 2'h0;
      end else begin
         col_reg <= col_next;
         row_reg <= row_next;
      end
   end

   assign scr.col = col_reg;
   assign scr.row = row_reg;
endmodule : dsp_scroll_pos
`default_nettype wire

// file: hw/dsp_saver_protect.sv
// Screen saver and screen protect gating for the operator display.
`timescale 1ns/10ps
`default_nettype none
module dsp_saver_protect
   import dsp_pkg::*;
#(
   parameter int MINUTE_CYC = DSP_MINUTE_CYC,
   parameter int SCROLL_CYC = DSP_SCROLL_CYC
) (
   // Clock and reset.
   input  wire logic                i_ref_clk,
   input  wire logic                i_rst,
   // Register port.
   input  wire logic [3:0]          i_addr,
   input  wire logic [15:0]         i_wdata,
   input  wire logic                i_wr,
   input  wire logic                i_rd,
   output logic [15:0]              o_rdata,
   // Operator keys.
   input  wire logic                i_key,
   output logic                     o_key_accept,
   // Keyword restriction from the controller.
   input  wire logic [DSP_FN_W-1:0] i_keyword_fn_en,
   // Screen and gating outputs.
   output logic                     o_saver_on,
   output logic [3:0]               o_saver_col,
   output logic [1:0]               o_saver_row,
   output logic [DSP_FN_W-1:0]      o_fn_en,
   output logic                     o_test_allow
);
   // ----------------------------------------------------------------------
   // Storage and helper signals
   // ----------------------------------------------------------------------
   logic [15:0]         saver_time_reg,  saver_time_next;
   logic [15:0]         protect_reg,     protect_next;
   logic [5:0]          ctrl_reg,        ctrl_next;
   logic [15:0]         rdata_reg,       rdata_next;
   logic [7:0]          idle_min_reg,    idle_min_next;
   dsp_state_t          state_reg,       state_next;
   logic                accept_reg,      accept_next;
   logic                saver_reg,       saver_next;
   logic [DSP_FN_W-1:0] fn_reg,          fn_next;
   logic                test_reg,        test_next;
   logic [3:0]          col_reg;
   logic [1:0]          row_reg;
   logic [7:0]          limit_min;
   logic                forced;
   logic                time_wr;
   logic                minute;
   logic [DSP_FN_W-1:0] prot_fn;
   dsp_scroll_if        scr ();

   // ----------------------------------------------------------------------
   // Register port
   // ----------------------------------------------------------------------

   // Writes update the words; reads return data one cycle later.
   always_comb begin
      saver_time_next = saver_time_reg;
      protect_next = protect_reg;
      ctrl_next = ctrl_reg;
      rdata_next = DSP_ZERO16;
      time_wr = 1'b0;
      if (i_wr) begin
         unique case (i_addr)
            DSP_ADDR_SAVER_TIME: begin
               saver_time_next = i_wdata;
               time_wr = (i_wdata != saver_time_reg);
            end
            DSP_ADDR_PROTECT_LVL: protect_next = i_wdata;
            DSP_ADDR_CTRL: ctrl_next = i_wdata[5:0];
            default: ;
         endcase
      end
      if (i_rd) begin
         unique case (i_addr)
            DSP_ADDR_SAVER_TIME: rdata_next = saver_time_reg;
            DSP_ADDR_PROTECT_LVL: rdata_next = protect_reg;
            DSP_ADDR_CTRL: rdata_next = {10'h0, ctrl_reg};
            DSP_ADDR_STATUS: rdata_next = {6'h0, idle_min_reg, state_reg};
            DSP_ADDR_FUNC_EN: rdata_next = {4'h0, fn_reg};
            default: rdata_next = DSP_ZERO16;
         endcase
      end
   end

   // Register storage.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         saver_time_reg <= DSP_ZERO16;
         protect_reg <= DSP_ZERO16;
         ctrl_reg <= 6'h0;
         rdata_reg <= DSP_ZERO16;
      end else begin
         saver_time_reg <= saver_time_next;
         protect_reg <= protect_next;
         ctrl_reg <= ctrl_next;
         rdata_reg <= rdata_next;
      end
   end

   // ----------------------------------------------------------------------
   // Saver time decode
   // ----------------------------------------------------------------------

   // Decode the signed minute setting into a limit.
   always_comb begin
      forced = saver_time_reg[15];
      if (saver_time_reg == DSP_ZERO16) begin
         limit_min = DSP_SAVER_DEFAULT_MIN[7:0];
      end else if (!saver_time_reg[15] && saver_time_reg > DSP_SAVER_MAX_MIN) begin
         limit_min = DSP_SAVER_MAX_MIN[7:0];
      end else begin
         limit_min = saver_time_reg[7:0];
      end
   end

   // ----------------------------------------------------------------------
   // Dividers and scroll position
   // ----------------------------------------------------------------------
   dsp_tick_div #(
      .MINUTE_CYC (MINUTE_CYC),
      .SCROLL_CYC (SCROLL_CYC)
   ) u_div (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      // Restart on key or setting change.
      .i_restart (i_key || time_wr),
      .o_minute  (minute),
      .scr       (scr)
   );

   dsp_scroll_pos u_pos (
      .i_ref_clk (i_ref_clk),
      .i_rst     (i_rst),
      .scr       (scr)
   );

   // Scrolling runs only while the saver shows.
   assign scr.run = saver_reg;

   // ----------------------------------------------------------------------
   // Saver state machine
   // ----------------------------------------------------------------------

   // Idle counting, saver entry and wake-up.
   always_comb begin
      state_next = state_reg;
      idle_min_next = idle_min_reg;
      accept_next = 1'b0;
      unique case (state_reg)
         DSP_IDLE: begin
            accept_next = i_key;
            if (i_key || time_wr) begin
               idle_min_next = 8'h0;
            end else if (minute && idle_min_reg != 8'hff) begin
               idle_min_next = idle_min_reg + 8'h1;
            end
            if (ctrl_reg[DSP_CTRL_SAVER_OFF]) begin
               state_next = DSP_IDLE;
            end else if (forced) begin
               state_next = DSP_FORCED;
            end else if (!i_key && !time_wr && idle_min_reg >= limit_min) begin
               state_next = DSP_SAVER;
            end
         end
         DSP_SAVER: begin
            idle_min_next = 8'h0;
            // First key wakes and is discarded.
            if (i_key || ctrl_reg[DSP_CTRL_SAVER_OFF] || time_wr) begin
               state_next = DSP_IDLE;
            end
         end
         DSP_FORCED: begin
            idle_min_next = 8'h0;
            // Keys never leave a forced saver.
            if (!forced || ctrl_reg[DSP_CTRL_SAVER_OFF]) begin
               state_next = DSP_IDLE;
            end
         end
      endcase
      saver_next = (state_next != DSP_IDLE);
   end

   // Saver registers.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= DSP_IDLE;
         idle_min_reg <= 8'h0;
         accept_reg <= 1'b0;
         saver_reg <= 1'b0;
         col_reg <= DSP_COL_LAST;
         row_reg <= 2'h0;
      end else begin
         state_reg <= state_next;
         idle_min_reg <= idle_min_next;
         accept_reg <= accept_next;
         saver_reg <= saver_next;
         col_reg <= scr.col;
         row_reg <= scr.row;
      end
   end

   // ----------------------------------------------------------------------
   // Protect gating
   // ----------------------------------------------------------------------

   // Function enables from the protect level.
   always_comb begin
      prot_fn = DSP_FN_ALL;
      if (protect_reg == DSP_PROTECT_LVL1) begin
         // Only the two top screens remain, plus the monitor top test when DSP_CTRL_MON_TEST_CFG is set.
         prot_fn = '0;
         prot_fn[DSP_FN_TOP_TIME] = 1'b1;
         prot_fn[DSP_FN_TOP_MON] = 1'b1;
         prot_fn[DSP_FN_MON_TOP_TST] = ctrl_reg[DSP_CTRL_MON_TEST_CFG];
      end else if (protect_reg == DSP_PROTECT_LVL2) begin
         prot_fn[DSP_FN_TEST] = 1'b0;
         prot_fn[DSP_FN_CONTRAST] = 1'b0;
         prot_fn[DSP_FN_TIME_SET] = 1'b0;
         prot_fn[DSP_FN_LANGUAGE] = 1'b0;
         prot_fn[DSP_FN_CASSETTE] = 1'b0;
         prot_fn[DSP_FN_MON_TOP_TST] = 1'b0;
      end
      fn_next = ctrl_reg[DSP_CTRL_KEYWORD_REG] ? i_keyword_fn_en : prot_fn;
      // Monitor testing needs the permit bit.
      test_next = ctrl_reg[DSP_CTRL_TEST_PERMIT] && fn_next[DSP_FN_MON_TOP_TST];
   end

   // Gating registers.
   always_ff @(posedge i_ref_clk or posedge i_rst) begin
      if (i_rst) begin
         fn_reg <= DSP_FN_ALL;
         test_reg <= 1'b0;
      end else begin
         fn_reg <= fn_next;
         test_reg <= test_next;
      end
   end

   // ----------------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------------
   a_wake_key_drop : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == DSP_SAVER && i_key) |=> !accept_reg && state_reg == DSP_IDLE)
      else $error("Wake key was not discarded.");
   a_saver_off_hold : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ctrl_reg[DSP_CTRL_SAVER_OFF] |=> state_reg == DSP_IDLE)
      else $error("Saver entered while disabled.");
   a_forced_entry : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (forced && !ctrl_reg[DSP_CTRL_SAVER_OFF])
      |=> saver_reg)
      else $error("Forced saver not shown.");
   a_idle_entry : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == DSP_IDLE && !forced && !i_key && !ctrl_reg[DSP_CTRL_SAVER_OFF]
       && !time_wr && idle_min_reg >= limit_min) |=> state_reg == DSP_SAVER)
      else $error("Saver not entered after idle time.");
   a_zero_default : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      saver_time_reg == DSP_ZERO16 |-> limit_min == 8'h0a)
      else $error("Zero setting not ten minutes.");
   a_clamp_max : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (!saver_time_reg[15] && saver_time_reg > 16'h00f0) |-> limit_min == 8'hf0)
      else $error("Large setting not clamped.");
   a_min_pass : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (saver_time_reg >= 16'h0001 && saver_time_reg <= 16'h00f0)
      |-> limit_min == saver_time_reg[7:0])
      else $error("Minute setting altered.");
   a_scroll_left : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (saver_reg && $past(saver_reg) && scr.step && scr.col != 4'h0)
      |=> scr.col == $past(scr.col) - 4'h1)
      else $error("Picture did not move left.");
   a_key_restart : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == DSP_IDLE && i_key) |=> idle_min_reg == 8'h0)
      else $error("Idle count not restarted.");
   a_level1_gate : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (protect_reg == 16'h0001 && !ctrl_reg[DSP_CTRL_KEYWORD_REG])
      |=> fn_reg[DSP_FN_CONTRAST:DSP_FN_MON_TEST] == 6'h0)
      else $error("Level one left functions on.");
   a_keyword_wins : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      ctrl_reg[DSP_CTRL_KEYWORD_REG] |=> fn_reg == $past(i_keyword_fn_en))
      else $error("Keyword restriction not applied.");
   a_test_permit : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      !ctrl_reg[DSP_CTRL_TEST_PERMIT] |=> !o_test_allow)
      else $error("Test allowed without permit.");
   a_forced_keys : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (state_reg == DSP_FORCED && forced && !ctrl_reg[DSP_CTRL_SAVER_OFF])
      |=> state_reg == DSP_FORCED && !accept_reg)
      else $error("Forced saver left on a key.");
   a_level2_gate : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (protect_reg == DSP_PROTECT_LVL2 && !ctrl_reg[DSP_CTRL_KEYWORD_REG])
      |=> !fn_reg[DSP_FN_TEST] && !fn_reg[DSP_FN_CONTRAST] && !fn_reg[DSP_FN_TIME_SET]
          && !fn_reg[DSP_FN_LANGUAGE] && !fn_reg[DSP_FN_CASSETTE] && fn_reg[DSP_FN_TOP_TIME])
      else $error("Level two left functions on.");
   a_other_levels : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (protect_reg != DSP_PROTECT_LVL1 && protect_reg != DSP_PROTECT_LVL2
       && !ctrl_reg[DSP_CTRL_KEYWORD_REG]) |=> fn_reg == DSP_FN_ALL)
      else $error("Other level restricted functions.");
   a_scroll_wrap : assert property (@(posedge i_ref_clk) disable iff (i_rst)
      (saver_reg && scr.step && scr.col == 4'h0)
      |=> scr.col == DSP_COL_LAST && scr.row != $past(scr.row))
      else $error("Picture did not wrap downward.");

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign o_rdata = rdata_reg;
   assign o_key_accept = accept_reg;
   assign o_saver_on = saver_reg;
   assign o_saver_col = col_reg;
   assign o_saver_row = row_reg;
   assign o_fn_en = fn_reg;
   assign o_test_allow = test_reg;
endmodule : dsp_saver_protect
`default_nettype wire

// file: sim/dsp_kp_model.sv
// Model of the operator panel keys and the controller keyword mask.
`timescale 1ns/10ps
`default_nettype none
module dsp_kp_model
   import dsp_pkg::*;
(
   // Clock.
   input  wire logic           i_ref_clk,
   // Panel and controller side.
   output logic                o_key,
   output logic [DSP_FN_W-1:0] o_keyword_fn_en
);
   // Keys are released and the keyword mask is fixed from time zero.
   initial begin
      o_key = 1'b0;
      o_keyword_fn_en = 12'h0a5;
   end
   // A press is a single-cycle pulse launched just after a rising edge.
   task automatic press();
      @(posedge i_ref_clk);
      o_key <= 1'b1;
      @(posedge i_ref_clk);
      o_key <= 1'b0;
   endtask : press
endmodule : dsp_kp_model
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking testbench for the display saver and protect block.
`timescale 1ns/10ps
`default_nettype none
module tb_top
   import dsp_pkg::*;
;
   localparam int MIN_C = 20;
   logic                clk, rst, wr, rd, key, acc, sav, tal;
   logic [3:0]          addr, col;
   logic [1:0]          row;
   logic [15:0]         wdata, rdata, d;
   logic [DSP_FN_W-1:0] kw, fn;
   int                  n_fail, num_checks, i;
   logic [3:0]          c;
   logic [15:0]         lv [6] = '{16'h3, 16'h0, 16'h1, 16'h1, 16'h2, 16'h2};
   logic [15:0]         ct [6] = '{16'h01, 16'h00, 16'h00, 16'h21, 16'h01, 16'h10};
   logic [11:0]         fe [6] = '{12'hfff, 12'hfff, 12'h003, 12'h803, 12'h237, 12'h0a5};
   logic                ta [6] = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};

   dsp_saver_protect #(.MINUTE_CYC(MIN_C), .SCROLL_CYC(4)) u_dut (
      .i_ref_clk(clk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
      .i_rd(rd), .o_rdata(rdata), .i_key(key), .o_key_accept(acc),
      .i_keyword_fn_en(kw), .o_saver_on(sav), .o_saver_col(col), .o_saver_row(row),
      .o_fn_en(fn), .o_test_allow(tal));
   dsp_kp_model u_kp (.i_ref_clk(clk), .o_key(key), .o_keyword_fn_en(kw));

   // Clock generation.
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end
   // Compares one value and counts the outcome.
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic wt(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : wt
   task automatic wreg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wreg
   task automatic rreg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1 v = rdata;
   endtask : rreg
   task automatic wrap_up();
      if (n_fail == 0 && num_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up
   // Watchdog against a hung run.
   initial begin
      #(20000 * 100);
      n_fail++;
      wrap_up();
   end
   // Main sequence.
   initial begin
      n_fail = 0; num_checks = 0; rst = 1'b1; addr = 4'h0; wdata = 16'h0; wr = 1'b0; rd = 1'b0;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      wt(1); chk({4'h0, fn}, {4'h0, DSP_FN_ALL});
      for (i = 0; i < 6; i++) begin
         wreg(DSP_ADDR_PROTECT_LVL, lv[i]);
         wreg(DSP_ADDR_CTRL, ct[i]);
         wt(3);
         chk({4'h0, fn}, {4'h0, fe[i]});
         chk({15'h0, tal}, {15'h0, ta[i]});
         rreg(DSP_ADDR_FUNC_EN, d); chk(d, {4'h0, fe[i]});
      end
      wreg(DSP_ADDR_CTRL, 16'h0000);
      wreg(DSP_ADDR_SAVER_TIME, 16'h0001);
      rreg(DSP_ADDR_SAVER_TIME, d); chk(d, 16'h0001);
      rreg(4'hf, d); chk(d, 16'h0000);
      wt(12); chk({15'h0, sav}, 16'h0000);
      wt(16); chk({15'h0, sav}, 16'h0001);
      c = col;
      for (i = 0; i < 20; i++) begin
         wt(1);
         if (col !== c) break;
      end
      chk({12'h0, col}, {12'h0, c - 4'h1});
      // Wait for the column to wrap, which moves the picture one row down.
      for (i = 0; i < 60; i++) begin
         wt(1);
         if (row !== 2'h0) break;
      end
      chk({14'h0, row}, 16'h0001);
      chk({12'h0, col}, {12'h0, DSP_COL_LAST});
      u_kp.press(); #1;
      chk({15'h0, sav}, 16'h0000);
      chk({15'h0, acc}, 16'h0000);
      u_kp.press(); #1; chk({15'h0, acc}, 16'h0001);
      wt(15); chk({15'h0, sav}, 16'h0000);
      wreg(DSP_ADDR_CTRL, 16'h0004);
      wt(60); chk({15'h0, sav}, 16'h0000);
      wreg(DSP_ADDR_CTRL, 16'h0000);
      wreg(DSP_ADDR_SAVER_TIME, 16'hffff);
      wt(2); chk({15'h0, sav}, 16'h0001);
      rreg(DSP_ADDR_STATUS, d); chk({14'h0, d[1:0]}, 16'h0002);
      u_kp.press(); #1; chk({15'h0, acc}, 16'h0000);
      chk({15'h0, sav}, 16'h0001);
      wreg(DSP_ADDR_SAVER_TIME, 16'h0005);
      wreg(DSP_ADDR_SAVER_TIME, 16'h0000);
      wt(10 * MIN_C - 10); chk({15'h0, sav}, 16'h0000);
      wt(20); chk({15'h0, sav}, 16'h0001);
      wreg(DSP_ADDR_SAVER_TIME, 16'h012c);
      wt(240 * MIN_C - 10); chk({15'h0, sav}, 16'h0000);
      wt(20); chk({15'h0, sav}, 16'h0001);
      wrap_up();
   end
endmodule : tb_top
`default_nettype wire
